// ==== shared/cs_ready_regs.vh ====
/*
 chip-select and ready generator: register offsets, fields and reset values.
 assumes inclusion by bare name from the design file.
*/
`ifndef CS_READY_REGS_VH
`define CS_READY_REGS_VH

// control block placement in i/o space, 256 bytes
`define CB_BASE_HI        8'hff
// register offsets within the control block
`define OFF_UPPER_CTRL    8'ha0
`define OFF_LOWER_CTRL    8'ha2
`define OFF_PERIPH_BASE   8'ha4
`define OFF_MID_BASE      8'ha6
`define OFF_MID_PERIPH    8'ha8
// reset values
`define RST_UPPER_CTRL    16'hfffb
`define RST_OTHER_CTRL    16'h0000
// field positions
`define F_ADDR_HI         15
`define F_ADDR_LO         6
`define F_MID_BASE_LO     9
`define F_MID_SIZE_HI     10
`define F_MID_SIZE_LO     8
`define F_PSEL_FULL       7
`define F_PSEL_MEM        6
`define F_IGNORE_EXT      2
`define F_WAIT_HI         1
`define F_WAIT_LO         0
// bus cycle shape
`define MIN_CYCLE_CLOCKS  4

`endif

// ==== design/chip_select_ready_generator.v ====
/*
 chip-select and ready generator for a 20-bit local bus, with its control
 registers inside the 256-byte control block in i/o space.
 assumes the bus controller gives a one-cycle start strobe in t1 with the
 address, space and write data, and that ext_ready_i is asynchronous.
*/
`timescale 1ns/1ps
`include "cs_ready_regs.vh"

module chip_select_ready_generator (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        ce_i,
  input  wire        cyc_start_i,
  input  wire [19:0] cyc_addr_i,
  input  wire        cyc_io_i,
  input  wire        cyc_wr_i,
  input  wire [15:0] cyc_wdata_i,
  input  wire        hold_grant_i,
  input  wire        ext_ready_i,
  output wire        cyc_end_o,
  output reg  [15:0] cb_rdata_o,
  output reg         upper_mem_select_n_o,
  output reg         lower_mem_select_n_o,
  output reg  [3:0]  mid_range_select_n_o,
  output reg  [4:0]  periph_select_n_o,
  output reg         periph_select5_or_latched_bit1_o,
  output reg         periph_select6_or_latched_bit2_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_T2   = 3'h1;
  localparam [2:0] ST_T3   = 3'h2;
  localparam [2:0] ST_TW   = 3'h3;
  localparam [2:0] ST_T4   = 3'h4;

  reg  [15:0] upper_select_control;
  reg  [15:0] lower_ctrl;
  reg  [15:0] periph_base;
  reg  [15:0] mid_base;
  reg  [15:0] mid_periph;
  reg         upper_en;
  reg         lower_en;
  reg         mid_en;
  reg         pbase_en;
  reg         pmode_en;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [1:0]  wait_cnt;
  reg         ignore_ext;
  reg         cb_cycle;
  reg         cb_write;
  reg  [7:0]  cb_off;
  reg  [15:0] cb_wdata;
  reg  [2:0]  rdy_sync;
  reg  [2:0]  ready_field;
  reg  [19:0] dec_addr;
  wire [6:0]  psel_hit;
  wire        ext_ready;
  wire        cb_hit;
  wire        upper_hit;
  wire        lower_hit;
  wire        mid_in_block;
  wire [3:0]  mid_hit;
  wire [2:0]  mid_size;
  wire [1:0]  mid_quarter;
  wire        psel_full;
  wire        wait_done;

  // wait count held in a ready field
  function [1:0] wait_of;
    input [2:0] field;
    begin
      wait_of = field[`F_WAIT_HI:`F_WAIT_LO];
    end
  endfunction

  // external ready after three stages, accepted when the last two agree
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdy_sync <= 3'h0;
    end else if (ce_i) begin
      rdy_sync <= {rdy_sync[1:0], ext_ready_i};
    end
  end
  reg ext_ready_q;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_ready_q <= 1'b0;
    end else if (ce_i && (rdy_sync[2] == rdy_sync[1])) begin
      ext_ready_q <= rdy_sync[2];
    end
  end
  assign ext_ready = ext_ready_q;

  // address decode of the incoming cycle
  assign cb_hit = cyc_io_i && (cyc_addr_i[19:16] == 4'h0)
                  && (cyc_addr_i[15:8] == `CB_BASE_HI);
  assign upper_hit = upper_en && !cyc_io_i
                     && (cyc_addr_i[19:10] >=
                         upper_select_control[`F_ADDR_HI:`F_ADDR_LO]);
  assign lower_hit = lower_en && !cyc_io_i
                     && (cyc_addr_i[19:10] <=
                         lower_ctrl[`F_ADDR_HI:`F_ADDR_LO]);
  assign mid_size = mid_periph[`F_MID_SIZE_HI:`F_MID_SIZE_LO];
  // block of 8k << size, base aligned on the block
  always @* begin
    dec_addr = cyc_addr_i >> (5'd13 + {2'b00, mid_size});
  end
  reg [19:0] base_shift;
  always @* begin
    base_shift = {mid_base[`F_ADDR_HI:`F_MID_BASE_LO], 13'h0000}
                 >> (5'd13 + {2'b00, mid_size});
  end
  assign mid_in_block = mid_en && !cyc_io_i && !upper_hit && !lower_hit
                        && (dec_addr == base_shift);
  reg [19:0] quarter_addr;
  always @* begin
    quarter_addr = cyc_addr_i >> (5'd11 + {2'b00, mid_size});
  end
  assign mid_quarter = quarter_addr[1:0];
  genvar gm;
  generate
    for (gm = 0; gm < 4; gm = gm + 1) begin : g_mid
      localparam [1:0] QUARTER = gm;
      assign mid_hit[gm] = mid_in_block && (mid_quarter == QUARTER);
    end
  endgenerate

  // seven 128-byte peripheral blocks above the base
  assign psel_full = mid_periph[`F_PSEL_FULL];
  wire       pmem = mid_periph[`F_PSEL_MEM];
  wire       pspace_ok = pbase_en && pmode_en
                         && (pmem ? !cyc_io_i
                                  : (cyc_io_i && cyc_addr_i[19:16] == 4'h0));
  wire [9:0] pbase_cmp = pmem ? periph_base[`F_ADDR_HI:`F_ADDR_LO]
                              : {4'h0, periph_base[11:6]};
  genvar gp;
  generate
    for (gp = 0; gp < 7; gp = gp + 1) begin : g_psel
      localparam [2:0] BLOCK = gp;
      assign psel_hit[gp] = pspace_ok && !cb_hit
                            && (cyc_addr_i[19:10] == pbase_cmp)
                            && (cyc_addr_i[9:7] == BLOCK);
    end
  endgenerate

  // ready field of the selected range, none gives zero waits with ready
  always @* begin
    if (cb_hit) begin
      ready_field = 3'b100;
    end else if (upper_hit) begin
      ready_field = upper_select_control[2:0];
    end else if (lower_hit) begin
      ready_field = lower_ctrl[2:0];
    end else if (mid_in_block) begin
      ready_field = mid_base[2:0];
    end else if (|psel_hit[3:0]) begin
      ready_field = periph_base[2:0];
    end else if (|psel_hit[6:4]) begin
      ready_field = mid_periph[2:0];
    end else begin
      ready_field = 3'b000;
    end
  end

  // cycle sequencer: t1 t2 t3 [tw..] t4
  assign wait_done = (wait_cnt == 2'h0)
                     && (ignore_ext || ext_ready);
  always @* begin
    case (state)
      ST_IDLE: next_state = cyc_start_i ? ST_T2 : ST_IDLE;
      ST_T2:   next_state = ST_T3;
      ST_T3:   next_state = wait_done ? ST_T4 : ST_TW;
      ST_TW:   next_state = wait_done ? ST_T4 : ST_TW;
      ST_T4:   next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  assign cyc_end_o = (state == ST_T4);

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= ST_IDLE;
      wait_cnt   <= 2'h0;
      ignore_ext <= 1'b0;
      cb_cycle   <= 1'b0;
      cb_write   <= 1'b0;
      cb_off     <= 8'h00;
      cb_wdata   <= 16'h0000;
    end else if (ce_i) begin
      state <= next_state;
      if (state == ST_IDLE && cyc_start_i) begin
        wait_cnt   <= wait_of(ready_field);
        ignore_ext <= ready_field[`F_IGNORE_EXT];
        cb_cycle   <= cb_hit;
        cb_write   <= cyc_wr_i;
        cb_off     <= cyc_addr_i[7:0];
        cb_wdata   <= cyc_wdata_i;
      end else if ((state == ST_T3 || state == ST_TW) && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end

  // control registers, written at t4 of a control block write
  wire cb_wr_now = ce_i && (state == ST_T4) && cb_cycle && cb_write;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      upper_select_control <= `RST_UPPER_CTRL;
      lower_ctrl  <= `RST_OTHER_CTRL;
      periph_base <= `RST_OTHER_CTRL;
      mid_base    <= `RST_OTHER_CTRL;
      mid_periph  <= `RST_OTHER_CTRL;
      upper_en    <= 1'b1;
      lower_en    <= 1'b0;
      mid_en      <= 1'b0;
      pbase_en    <= 1'b0;
      pmode_en    <= 1'b0;
    end else if (cb_wr_now) begin
      case (cb_off)
        `OFF_UPPER_CTRL: upper_select_control <= cb_wdata;
        `OFF_LOWER_CTRL: begin
          lower_ctrl <= cb_wdata;
          lower_en   <= 1'b1;
        end
        `OFF_PERIPH_BASE: begin
          periph_base <= cb_wdata;
          pbase_en    <= 1'b1;
        end
        `OFF_MID_BASE: begin
          mid_base <= cb_wdata;
          mid_en   <= 1'b1;
        end
        `OFF_MID_PERIPH: begin
          mid_periph <= cb_wdata;
          pmode_en   <= 1'b1;
        end
        default: upper_en <= upper_en;
      endcase
    end
  end

  // read data, registered at start of a control block read
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cb_rdata_o <= 16'h0000;
    end else if (ce_i && state == ST_IDLE && cyc_start_i && cb_hit && !cyc_wr_i) begin
      case (cyc_addr_i[7:0])
        `OFF_UPPER_CTRL:  cb_rdata_o <= upper_select_control;
        `OFF_LOWER_CTRL:  cb_rdata_o <= lower_ctrl;
        `OFF_PERIPH_BASE: cb_rdata_o <= periph_base;
        `OFF_MID_BASE:    cb_rdata_o <= mid_base;
        `OFF_MID_PERIPH:  cb_rdata_o <= mid_periph;
        default:          cb_rdata_o <= 16'h0000;
      endcase
    end
  end

  // select outputs: set at the end of t1, released after t4, not set for a cycle that starts during grant
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      upper_mem_select_n_o             <= 1'b1;
      lower_mem_select_n_o             <= 1'b1;
      mid_range_select_n_o             <= 4'hf;
      periph_select_n_o                <= 5'h1f;
      periph_select5_or_latched_bit1_o <= 1'b1;
      periph_select6_or_latched_bit2_o <= 1'b1;
    end else if (ce_i) begin
      if (state == ST_IDLE && cyc_start_i && !hold_grant_i) begin
        upper_mem_select_n_o <= !upper_hit;
        lower_mem_select_n_o <= !lower_hit;
        mid_range_select_n_o <= ~mid_hit;
        periph_select_n_o    <= ~psel_hit[4:0];
        if (psel_full) begin
          periph_select5_or_latched_bit1_o <= !psel_hit[5];
          periph_select6_or_latched_bit2_o <= !psel_hit[6];
        end else begin
          periph_select5_or_latched_bit1_o <= cyc_addr_i[1];
          periph_select6_or_latched_bit2_o <= cyc_addr_i[2];
        end
      end else if (state == ST_T4) begin
        upper_mem_select_n_o <= 1'b1;
        lower_mem_select_n_o <= 1'b1;
        mid_range_select_n_o <= 4'hf;
        periph_select_n_o    <= 5'h1f;
        if (psel_full) begin
          periph_select5_or_latched_bit1_o <= 1'b1;
          periph_select6_or_latched_bit2_o <= 1'b1;
        end
      end else if (!psel_full && state == ST_IDLE && hold_grant_i) begin
        periph_select5_or_latched_bit1_o <= periph_select5_or_latched_bit1_o;
        periph_select6_or_latched_bit2_o <= periph_select6_or_latched_bit2_o;
      end
    end
  end

endmodule // chip_select_ready_generator

// ==== dv/cs_ready_props.sv ====
/* checker for the chip-select and ready generator, on its top ports only.
 assumes binding into every chip_select_ready_generator instance. */
`timescale 1ns/1ps
module cs_ready_props (
  input wire        clk_i,
  input wire        reset_i,
  input wire        ce_i,
  input wire        cyc_start_i,
  input wire [19:0] cyc_addr_i,
  input wire        cyc_io_i,
  input wire        cyc_wr_i,
  input wire [15:0] cyc_wdata_i,
  input wire        hold_grant_i,
  input wire        ext_ready_i,
  input wire        cyc_end_o,
  input wire [15:0] cb_rdata_o,
  input wire        upper_mem_select_n_o,
  input wire        lower_mem_select_n_o,
  input wire [3:0]  mid_range_select_n_o,
  input wire [4:0]  periph_select_n_o,
  input wire        periph_select5_or_latched_bit1_o,
  input wire        periph_select6_or_latched_bit2_o
);
  reg         busy;
  wire [10:0] sel = {upper_mem_select_n_o, lower_mem_select_n_o, mid_range_select_n_o,
                     periph_select_n_o};
  wire        tk  = ce_i && cyc_start_i && !busy;
  wire        cbk = cyc_io_i && cyc_addr_i[19:8] == 12'h0ff;
  // taken cycle in progress
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) busy <= 1'b0;
    else if (ce_i && cyc_end_o) busy <= 1'b0;
    else if (tk) busy <= 1'b1;
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_t2_t3;
    !cyc_end_o [*2];
  endsequence
  AST_RST_IDLE:
    assert property ($fell(reset_i) |-> &sel && periph_select5_or_latched_bit1_o
      && periph_select6_or_latched_bit2_o) else $error("select low after reset");
  AST_END_PULSE:
    assert property (ce_i && cyc_end_o |=> !cyc_end_o) else $error("end not one clock");
  AST_MIN_CYCLE:
    assert property (tk |=> s_t2_t3) else $error("cycle shorter than four clocks");
  AST_CB_ZERO_WAIT:
    assert property (tk && cbk |=> s_t2_t3 ##1 cyc_end_o) else $error("control cycle not 4");
  AST_UPPER_TOP:
    assert property (tk && !hold_grant_i && !cyc_io_i && cyc_addr_i[19:10] == 10'h3ff
      |=> !upper_mem_select_n_o) else $error("top of memory not selected");
  AST_ONE_SEL:
    assert property ($onehot0(~sel)) else $error("two selects active");
  AST_SEL_RELEASE:
    assert property (ce_i && cyc_end_o |=> &sel) else $error("select held past end");
  AST_GRANT_KEEP:
    assert property (tk && hold_grant_i && &sel |=> &sel [*3]) else $error("select in grant");
  AST_LATCH_HOLD:
    assert property (hold_grant_i ##1 hold_grant_i |-> $stable(periph_select5_or_latched_bit1_o)
      && $stable(periph_select6_or_latched_bit2_o)) else $error("latched bit moved in grant");
endmodule // cs_ready_props

bind chip_select_ready_generator cs_ready_props u_cs_ready_props (.*);

// ==== dv/ext_ready_device.sv ====
/* external device model driving a pulled-up ready line.
 assumes active-low selects from the block and a wait length from the bench. */
`timescale 1ns/1ps
module ext_ready_device (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [10:0] sel_n_i,
  input  wire [4:0]  delay_i,
  output wire        ready_o
);
  reg [4:0] cnt;
  // pulled up while idle, held low for delay clocks once selected
  assign ready_o = &sel_n_i || cnt >= delay_i;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) cnt <= 5'h00;
    else if (&sel_n_i) cnt <= 5'h00;
    else if (cnt < delay_i) cnt <= cnt + 5'h01;
  end
endmodule // ext_ready_device

// ==== dv/test_chip_select_ready_generator.sv ====
/* self-checking bench for the chip-select and ready generator.
 assumes the ext_ready_device model and the bound cs_ready_props checker. */
`timescale 1ns/1ps
module test_chip_select_ready_generator;
  reg         clk_i, reset_i, ce_i, cyc_start_i, cyc_io_i, cyc_wr_i, hold_grant_i;
  reg  [19:0] cyc_addr_i;
  reg  [15:0] cyc_wdata_i;
  reg  [4:0]  dly;
  reg  [31:0] seed;
  wire        ext_ready_i, cyc_end_o, u_n, l_n, p5, p6;
  wire [15:0] cb_rdata_o;
  wire [3:0]  m_n;
  wire [4:0]  ps_n;
  wire [12:0] sel_v = {u_n, l_n, m_n, ps_n, p5, p6};
  integer     fail_count, num_checks, n, k, w;
  reg         lat_mode;
  reg  [1:0]  lat_bits;
  reg  [12:0] exp_sel;
  chip_select_ready_generator u_chip_select_ready_generator (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .cyc_start_i(cyc_start_i),
    .cyc_addr_i(cyc_addr_i), .cyc_io_i(cyc_io_i), .cyc_wr_i(cyc_wr_i),
    .cyc_wdata_i(cyc_wdata_i), .hold_grant_i(hold_grant_i), .ext_ready_i(ext_ready_i),
    .cyc_end_o(cyc_end_o), .cb_rdata_o(cb_rdata_o), .upper_mem_select_n_o(u_n),
    .lower_mem_select_n_o(l_n), .mid_range_select_n_o(m_n), .periph_select_n_o(ps_n),
    .periph_select5_or_latched_bit1_o(p5), .periph_select6_or_latched_bit2_o(p6));
  ext_ready_device u_ext_ready_device (.clk_i(clk_i), .reset_i(reset_i),
    .sel_n_i(sel_v[12:2]), .delay_i(dly), .ready_o(ext_ready_i));
  function [19:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed[19:0];
    end
  endfunction
  task chk(input string what, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
    end
  endtask
  task chk_n(input string what, input integer lo, input integer hi, input integer g);
    begin
      num_checks = num_checks + 1;
      if (g < lo || g > hi) begin
        fail_count = fail_count + 1;
        $display("unexpected %s: expected %0d to %0d, seen %0d", what, lo, hi, g);
      end
    end
  endtask
  // one bus cycle; pos is the select bit expected low, n ends as the count of clocks from t2 through t4
  task cyc(input [19:0] a, input io, input wr, input [15:0] d, input integer pos);
    begin
      cyc_addr_i = a;
      cyc_io_i = io;
      cyc_wr_i = wr;
      cyc_wdata_i = d;
      cyc_start_i = 1'b1;
      if (ce_i && !hold_grant_i) lat_bits = lat_mode ? {a[1], a[2]} : 2'b11;
      exp_sel = pos < 0 ? 13'h1fff : ~(13'h0001 << pos) & 13'h1fff;
      if (lat_mode) exp_sel[1:0] = lat_bits;
      @(posedge clk_i);
      #10 cyc_start_i = 1'b0;
      chk("selects", {3'b000, exp_sel}, {3'b000, sel_v});
      n = 1;
      while (cyc_end_o !== 1'b1 && n < 60) begin
        @(posedge clk_i);
        #10 n = n + 1;
      end
      @(posedge clk_i);
      #10;
    end
  endtask
  task wreg(input [7:0] off, input [15:0] d);
    begin
      cyc({12'h0ff, off}, 1'b1, 1'b1, d, -1);
      chk_n("control latency", 3, 3, n);
      if (off == 8'ha8) lat_mode = !d[7];
    end
  endtask
  task rreg(input [7:0] off, input [15:0] e);
    begin
      cyc({12'h0ff, off}, 1'b1, 1'b0, 16'h0000, -1);
      chk("control read", e, cb_rdata_o);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #2000000 fail_count = fail_count + 1;
    complete_run;
  end
  initial begin
    {fail_count, num_checks, seed} = {32'd0, 32'd0, 32'd30};
    {reset_i, ce_i, cyc_start_i, cyc_io_i, cyc_wr_i, hold_grant_i} = 6'b110000;
    {cyc_addr_i, cyc_wdata_i, dly} = 41'h0;
    lat_mode = 1'b1;
    lat_bits = 2'b11;
    repeat (6) @(posedge clk_i);
    #10 reset_i = 1'b0;
    chk("reset selects", 16'h1fff, {3'b000, sel_v});
    rreg(8'ha0, 16'hfffb);
    rreg(8'h10, 16'h0000);
    cyc(20'hffff0, 1'b0, 1'b0, 16'h0000, 12);
    chk_n("upper latency", 6, 6, n);
    dly = 5'd12;
    cyc(20'hffc00 | (rnd() & 20'h003fe), 1'b0, 1'b0, 16'h0000, 12);
    chk_n("upper slow latency", 13, 20, n);
    cyc(20'hffbfe, 1'b0, 1'b0, 16'h0000, -1);
    cyc(rnd() & 20'h003fe, 1'b0, 1'b0, 16'h0000, -1);
    for (w = 0; w < 4; w = w + 1) begin
      wreg(8'ha2, {13'h0000, 1'b1, w[1:0]});
      rreg(8'ha2, {13'h0000, 1'b1, w[1:0]});
      cyc(rnd() & 20'h003fe, 1'b0, 1'b1, rnd() & 20'h0ffff, 11);
      chk_n("lower latency", 3 + w, 3 + w, n);
    end
    wreg(8'ha2, 16'h0003);
    cyc(20'h00000, 1'b0, 1'b0, 16'h0000, 11);
    chk_n("lower combined latency", 13, 20, n);
    dly = 5'd0;
    wreg(8'ha6, 16'h2004);
    wreg(8'ha8, 16'h00c6);
    for (k = 0; k < 4; k = k + 1)
      cyc(20'h20000 | {k[1:0], 11'h000} | (rnd() & 20'h007fe), 1'b0, 1'b0, 16'h0000, 7 + k);
    wreg(8'ha4, 16'h4005);
    for (k = 0; k < 7; k = k + 1) begin
      cyc(20'h40000 | {k[2:0], 7'h00} | (rnd() & 20'h0007e), 1'b0, 1'b0, 16'h0000,
          k < 5 ? 2 + k : 6 - k);
      chk_n("periph latency", k < 4 ? 4 : 5, k < 4 ? 4 : 5, n);
    end
    wreg(8'ha8, 16'h0046);
    cyc(20'h40006, 1'b0, 1'b0, 16'h0000, 2);
    hold_grant_i = 1'b1;
    cyc(20'h40080, 1'b0, 1'b0, 16'h0000, -1);
    hold_grant_i = 1'b0;
    ce_i = 1'b0;
    cyc(20'hffff0, 1'b0, 1'b0, 16'h0000, -1);
    ce_i = 1'b1;
    cyc_addr_i = 20'hffff0;
    cyc_start_i = 1'b1;
    @(posedge clk_i);
    #10 {cyc_start_i, reset_i} = 2'b01;
    lat_mode = 1'b1;
    lat_bits = 2'b11;
    #10 chk("reset mid-cycle", 16'h1fff, {3'b000, sel_v});
    @(posedge clk_i);
    #10 reset_i = 1'b0;
    cyc(20'h00000, 1'b0, 1'b0, 16'h0000, -1);
    complete_run;
  end
endmodule // test_chip_select_ready_generator
